// File: src/jcs_pkg.sv
package jcs_pkg;

    // Register map, byte addresses
    localparam logic [7:0] CTRL_OFFS = 8'h00;
    localparam logic [7:0] STAT_OFFS = 8'h04;

    // Control word fields
    localparam int CTRL_INCH1_BIT = 8;
    localparam int CTRL_INCH2_BIT = 9;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK  = 32'h0000_0300;

    // Status word fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_REF_LSB   = 4;
    localparam int STAT_RAMP_BIT  = 6;
    localparam int STAT_JOGEN_BIT = 7;
    localparam int STAT_STOK_BIT  = 8;
    localparam int STAT_PINS_LSB  = 12;

    // Speed target selection
    typedef enum logic [1:0] {
        REF_ZERO   = 2'h0,
        REF_NORMAL = 2'h1,
        REF_JOG1   = 2'h2,
        REF_JOG2   = 2'h3
    } jcs_ref_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_NDEC,
        ST_JOG,
        ST_JDEC
    } jcs_state_t;

    // Command pins, synchronised as one group
    typedef struct packed {
        logic local_sel;
        logic start;
        logic permit;
        logic jog2;
        logic jog1;
    } jcs_pins_t;

    // Drive commands handed to the ramp generator
    typedef struct packed {
        jcs_ref_t ref_sel;
        logic     ramp_jog;
        logic     run;
    } jcs_drv_t;

endpackage

// File: src/jcs_sync.sv
module jcs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rstn_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;

endmodule // jcs_sync

// File: src/jcs_prio.sv
module jcs_prio (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    // Requests
    input  wire logic act1_i,
    input  wire logic act2_i,
    // Grant: 1 selects jog two
    output logic      sel2_o
);

    logic owner2_reg;
    logic owner2_next;

    // Holder keeps priority; jog one wins a tie
    assign owner2_next = (act1_i && act2_i) ? owner2_reg : (act2_i && !act1_i);

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            owner2_reg <= 1'b0;
        else
            owner2_reg <= owner2_next;
    end

    assign sel2_o = owner2_next;

endmodule // jcs_prio

// File: src/jcs_sequencer.sv
// Notes on behaviour
// - Jog permit changes are ignored while start is on; normal reference kept.
// - Permit present when start drops enables jogging at once.
// - Start drop decelerates on the normal ramp.
// - Jog request during that deceleration switches to the jog ramp.
// - Jog request plus permit, start off, selects the jog reference.
// - Jog release decelerates to zero on the jog ramp, even if permit drops.
// - No jogging at all under local control.
// - Jog enabled blocks start; after permit drops a fresh start edge is needed.
// - With both jog requests on, the first one keeps priority until released.
// - Fieldbus inching bits jog with jog references and ramps, no permit.
// - Jog activation starts and accelerates on the jog ramp.
// - Two jog functions, each with its own request and reference.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
module jcs_sequencer #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    // APB slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // Command pins
    input  wire logic              jog1_req_i,
    input  wire logic              jog2_req_i,
    input  wire logic              jog_permit_i,
    input  wire logic              start_cmd_i,
    input  wire logic              local_sel_i,
    // Ramp generator feedback, same clock
    input  wire logic              zero_speed_i,
    // Drive commands
    output jcs_pkg::jcs_ref_t      ref_sel_o,
    output logic                   ramp_jog_o,
    output logic                   run_o
);

    // Synchronised pins
    jcs_pkg::jcs_pins_t pins_raw;
    jcs_pkg::jcs_pins_t pins;

    assign pins_raw.local_sel = local_sel_i;
    assign pins_raw.start     = start_cmd_i;
    assign pins_raw.permit    = jog_permit_i;
    assign pins_raw.jog2      = jog2_req_i;
    assign pins_raw.jog1      = jog1_req_i;

    jcs_sync #(
        .WIDTH ($bits(jcs_pkg::jcs_pins_t))
    ) u_sync (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .d_i    (pins_raw),
        .q_o    (pins)
    );

    // Registers
    logic [31:0]         ctrl_reg;
    logic [31:0]         ctrl_next;
    logic                pready_reg;
    logic                pslverr_reg;
    logic [31:0]         prdata_reg;
    logic                jog_en_reg;
    logic                jog_en_next;
    logic                start_ok_reg;
    logic                start_ok_next;
    jcs_pkg::jcs_state_t state_reg;
    jcs_pkg::jcs_state_t state_next;
    jcs_pkg::jcs_drv_t   drv_reg;
    jcs_pkg::jcs_drv_t   drv_next;

    // Register select on the low address byte
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offs);
        addr_hit = (addr == offs);
    endfunction

    // APB decode
    wire apb_acc    = psel_i && penable_i;
    wire apb_done   = apb_acc && pready_reg;
    wire hit_ctrl   = addr_hit(paddr_i[7:0], jcs_pkg::CTRL_OFFS);
    wire hit_stat   = addr_hit(paddr_i[7:0], jcs_pkg::STAT_OFFS);
    wire addr_ok    = hit_ctrl || hit_stat;
    wire ctrl_wr    = apb_done && pwrite_i && hit_ctrl;
    wire [31:0] stat_word;
    wire [31:0] rd_word;

    assign ctrl_next = ctrl_wr ? (pwdata_i & jcs_pkg::CTRL_MASK) : ctrl_reg;

    // Status fields in place
    wire [31:0] stat_state = 32'(state_reg) << jcs_pkg::STAT_STATE_LSB;
    wire [31:0] stat_ref   = 32'(drv_reg.ref_sel) << jcs_pkg::STAT_REF_LSB;
    wire [31:0] stat_ramp  = 32'(drv_reg.ramp_jog) << jcs_pkg::STAT_RAMP_BIT;
    wire [31:0] stat_jogen = 32'(jog_en_reg) << jcs_pkg::STAT_JOGEN_BIT;
    wire [31:0] stat_stok  = 32'(start_ok_reg) << jcs_pkg::STAT_STOK_BIT;
    wire [31:0] stat_pins  = 32'(pins) << jcs_pkg::STAT_PINS_LSB;

    assign stat_word = stat_state | stat_ref | stat_ramp
                     | stat_jogen | stat_stok | stat_pins;

    assign rd_word = hit_ctrl ? ctrl_reg :
                     hit_stat ? stat_word : 32'h0000_0000;

    // Fieldbus inching bits
    wire inch1 = ctrl_reg[jcs_pkg::CTRL_INCH1_BIT];
    wire inch2 = ctrl_reg[jcs_pkg::CTRL_INCH2_BIT];

    // Permit follows the pin only while start is off
    assign jog_en_next = pins.start ? jog_en_reg : pins.permit;

    // Start is honoured only after it has been low with jogging disabled
    assign start_ok_next = jog_en_reg ? 1'b0 :
                           !pins.start ? 1'b1 : start_ok_reg;

    // Per-function jog activity
    wire        remote   = !pins.local_sel;
    wire [1:0]  jog_pin  = {pins.jog2, pins.jog1};
    wire [1:0]  inch_bit = {inch2, inch1};
    logic [1:0] act;

    for (genvar g = 0; g < $bits(act); g++)
    begin : g_act
        assign act[g] = remote && ((jog_en_reg && jog_pin[g]) || inch_bit[g]);
    end

    wire act1    = act[0];
    wire act2    = act[1];
    wire jog_act = |act;
    wire sel2;

    // Priority between the two jog functions
    jcs_prio u_prio (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .act1_i (act1),
        .act2_i (act2),
        .sel2_o (sel2)
    );

    // Normal start needs a fresh edge with jogging off
    wire normal_go = pins.start && start_ok_reg && !jog_en_reg;

    // Sequencer
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            jcs_pkg::ST_IDLE:
            begin
                if (jog_act)
                    state_next = jcs_pkg::ST_JOG;
                else if (normal_go)
                    state_next = jcs_pkg::ST_RUN;
            end
            jcs_pkg::ST_RUN:
            begin
                if (!pins.start)
                    state_next = jcs_pkg::ST_NDEC;
            end
            jcs_pkg::ST_NDEC:
            begin
                if (jog_act)
                    state_next = jcs_pkg::ST_JOG;
                else if (normal_go)
                    state_next = jcs_pkg::ST_RUN;
                else if (zero_speed_i)
                    state_next = jcs_pkg::ST_IDLE;
            end
            jcs_pkg::ST_JOG:
            begin
                if (!jog_act)
                    state_next = jcs_pkg::ST_JDEC;
            end
            jcs_pkg::ST_JDEC:
            begin
                if (jog_act)
                    state_next = jcs_pkg::ST_JOG;
                else if (zero_speed_i)
                    state_next = jcs_pkg::ST_IDLE;
            end
            default:
                state_next = jcs_pkg::ST_IDLE;
        endcase
    end

    // Outputs decoded from the next state, so they change with it
    always_comb
    begin
        drv_next.ref_sel  = jcs_pkg::REF_ZERO;
        drv_next.ramp_jog = 1'b0;
        drv_next.run      = 1'b1;
        unique case (state_next)
            jcs_pkg::ST_IDLE:
                drv_next.run = 1'b0;
            jcs_pkg::ST_RUN:
                drv_next.ref_sel = jcs_pkg::REF_NORMAL;
            jcs_pkg::ST_NDEC:
                drv_next.ramp_jog = 1'b0;
            jcs_pkg::ST_JOG:
            begin
                drv_next.ref_sel  = sel2 ? jcs_pkg::REF_JOG2
                                         : jcs_pkg::REF_JOG1;
                drv_next.ramp_jog = 1'b1;
            end
            jcs_pkg::ST_JDEC:
                drv_next.ramp_jog = 1'b1;
            default:
                drv_next.run = 1'b0;
        endcase
    end

    // Sequencer state
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            state_reg <= jcs_pkg::ST_IDLE;
        else
            state_reg <= state_next;
    end

    // Drive command register
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            drv_reg <= '0;
        else
            drv_reg <= drv_next;
    end

    // Jog enable latch
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            jog_en_reg <= 1'b0;
        else
            jog_en_reg <= jog_en_next;
    end

    // Start permission
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            start_ok_reg <= 1'b0;
        else
            start_ok_reg <= start_ok_next;
    end

    // APB: one wait state, answer registered
    wire        apb_first    = apb_acc && !pready_reg;
    wire        pslverr_next = apb_first && !addr_ok;
    wire [31:0] prdata_next  = (apb_first && !pwrite_i) ? rd_word
                                                        : 32'h0000_0000;

    // Control word
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ctrl_reg <= jcs_pkg::CTRL_RESET;
        else
            ctrl_reg <= ctrl_next;
    end

    // Answer strobe
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pready_reg <= 1'b0;
        else
            pready_reg <= apb_first;
    end

    // Error strobe
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pslverr_reg <= 1'b0;
        else
            pslverr_reg <= pslverr_next;
    end

    // Read data
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            prdata_reg <= 32'h0000_0000;
        else
            prdata_reg <= prdata_next;
    end

    // Outputs straight from flops
    assign prdata_o   = prdata_reg;
    assign pready_o   = pready_reg;
    assign pslverr_o  = pslverr_reg;
    assign ref_sel_o  = drv_reg.ref_sel;
    assign ramp_jog_o = drv_reg.ramp_jog;
    assign run_o      = drv_reg.run;

endmodule // jcs_sequencer

// File: verification/jcs_sva.sv
module jcs_sva (
    // Clock and reset
    input wire logic              mclk_i,
    input wire logic              rstn_i,
    // APB and pins
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic [7:0]        paddr_i,
    input wire logic              start_cmd_i,
    input wire logic              local_sel_i,
    // Outputs watched
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire jcs_pkg::jcs_ref_t ref_sel_o,
    input wire logic              ramp_jog_o,
    input wire logic              run_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    a_ready_one_wait: assert property (psel_i && !penable_i ##1 psel_i && penable_i
        |-> !pready_o ##1 pready_o) else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_err_decode: assert property (pready_o |-> pslverr_o == !(paddr_i == jcs_pkg::CTRL_OFFS
        || paddr_i == jcs_pkg::STAT_OFFS)) else $error("pslverr decode wrong");
    a_err_alone: assert property (!pready_o |-> !pslverr_o && prdata_o == 32'h0)
        else $error("error or data outside answer");
    a_jog_ramp: assert property (ref_sel_o[1] |-> ramp_jog_o && run_o)
        else $error("jog reference without jog ramp");
    a_normal_ramp: assert property (ref_sel_o == jcs_pkg::REF_NORMAL |-> !ramp_jog_o && run_o)
        else $error("normal reference with jog ramp");
    a_jog_release: assert property (ref_sel_o[1] ##1 ref_sel_o == jcs_pkg::REF_ZERO && run_o
        |-> ramp_jog_o) else $error("jog release not on jog ramp");
    a_local_block: assert property (local_sel_i [*4] |-> !ref_sel_o[1])
        else $error("jogging under local control");
    a_start_holds: assert property (start_cmd_i [*4] ##0 ref_sel_o == jcs_pkg::REF_NORMAL
        |=> ref_sel_o == jcs_pkg::REF_NORMAL) else $error("normal run left");
    c_jog2: cover property (ref_sel_o == jcs_pkg::REF_JOG2);
    c_err: cover property (pslverr_o);
    c_jog_stop: cover property (ramp_jog_o && ref_sel_o == jcs_pkg::REF_ZERO);
    c_decel_jog: cover property (run_o && !ramp_jog_o && ref_sel_o == jcs_pkg::REF_ZERO
        ##1 ref_sel_o[1]);
endmodule // jcs_sva

bind jcs_sequencer jcs_sva u_sva (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .paddr_i(paddr_i), .start_cmd_i(start_cmd_i),
    .local_sel_i(local_sel_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ref_sel_o(ref_sel_o), .ramp_jog_o(ramp_jog_o), .run_o(run_o));

// File: verification/jcs_switch_model.sv
module jcs_switch_model #(
    parameter int STOP_CYC = 12
) (
    // Clock
    input  wire logic               mclk_i,
    // Operator commands and drive state
    input  wire jcs_pkg::jcs_pins_t cmd_i,
    input  wire logic               run_i,
    input  wire jcs_pkg::jcs_ref_t  ref_i,
    // Pins and ramp feedback
    output jcs_pkg::jcs_pins_t      pins_o,
    output logic                    zero_speed_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial pins_o = '0;
    // Motor coasts down STOP_CYC cycles once the target is zero
    always @(posedge mclk_i)
    begin
        pins_o <= cmd_i;
        cnt    <= (run_i && ref_i == jcs_pkg::REF_ZERO) ? cnt + 1 : 0;
    end
    assign zero_speed_o = (cnt >= STOP_CYC);
endmodule // jcs_switch_model

// File: verification/jcs_sequencer_bench.sv
module jcs_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic               mclk_i = 0;
    logic               rstn_i = 0;
    logic               psel = 0, pen = 0, pwr = 0, rdy, err, zs, ramp, run;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0, prdata;
    jcs_pkg::jcs_ref_t  rsel;
    jcs_pkg::jcs_pins_t cmd = '0, pins;
    int                 errors = 0, samples_checked = 0;
    initial forever #20 mclk_i = ~mclk_i;
    jcs_sequencer u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(rdy), .pslverr_o(err), .jog1_req_i(pins.jog1), .jog2_req_i(pins.jog2),
        .jog_permit_i(pins.permit), .start_cmd_i(pins.start), .local_sel_i(pins.local_sel),
        .zero_speed_i(zs), .ref_sel_o(rsel), .ramp_jog_o(ramp), .run_o(run));
    jcs_switch_model u_sw (.mclk_i(mclk_i), .cmd_i(cmd), .run_i(run), .ref_i(rsel),
        .pins_o(pins), .zero_speed_o(zs));
    task summarize;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, e, input logic er);
        int i;
        @(posedge mclk_i);
        {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge mclk_i);
        pen <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge mclk_i);
            if (rdy === 1'b1)
                break;
        end
        {psel, pen} <= 2'h0;
        chk("pready", 32'h0000_0001, {31'h0, rdy});
        chk("pslverr", er, err);
        if (!w)
            chk("prdata", e, prdata);
        if (i == 20)
            summarize();
    endtask
    task drv(input jcs_pkg::jcs_ref_t r, input logic rj, rn, input int hold);
        int i;
        if (hold > 0)
            repeat (hold) @(posedge mclk_i);
        for (i = 0; hold == 0 && i < 40 && {rsel, ramp, run} !== {r, rj, rn}; i++)
            @(posedge mclk_i);
        chk("drive", {r, rj, rn}, {rsel, ramp, run});
        if (i == 40)
            summarize();
    endtask
    initial
    begin
        repeat (10) @(posedge mclk_i);
        rstn_i <= 1'b1;
        drv(jcs_pkg::REF_ZERO, 0, 0, 1);
        apb(0, jcs_pkg::CTRL_OFFS, 0, jcs_pkg::CTRL_RESET, 0);
        apb(1, jcs_pkg::CTRL_OFFS, 32'hFFFF_FCFF, 0, 0);
        apb(0, jcs_pkg::CTRL_OFFS, 0, 32'h0000_0000, 0);
        apb(1, 8'h0C, 32'hFFFF_FFFF, 0, 1);
        apb(0, 8'h08, 0, 32'h0000_0000, 1);
        apb(1, jcs_pkg::STAT_OFFS, 32'hFFFF_FFFF, 0, 0);
        apb(0, jcs_pkg::STAT_OFFS, 0, 32'h0000_0001 << jcs_pkg::STAT_STOK_BIT, 0);
        cmd.start <= 1'b1;
        drv(jcs_pkg::REF_NORMAL, 0, 1, 0);
        cmd.permit <= 1'b1;
        drv(jcs_pkg::REF_NORMAL, 0, 1, 8);
        cmd.start <= 1'b0;
        drv(jcs_pkg::REF_ZERO, 0, 1, 0);
        cmd.jog1 <= 1'b1;
        drv(jcs_pkg::REF_JOG1, 1, 1, 0);
        cmd.jog2 <= 1'b1;
        drv(jcs_pkg::REF_JOG1, 1, 1, 8);
        cmd.jog1 <= 1'b0;
        drv(jcs_pkg::REF_JOG2, 1, 1, 0);
        {cmd.jog2, cmd.permit} <= 2'h0;
        drv(jcs_pkg::REF_ZERO, 1, 1, 0);
        drv(jcs_pkg::REF_ZERO, 0, 0, 0);
        cmd.permit <= 1'b1;
        drv(jcs_pkg::REF_ZERO, 0, 0, 4);
        cmd.start <= 1'b1;
        drv(jcs_pkg::REF_ZERO, 0, 0, 8);
        cmd.permit <= 1'b0;
        drv(jcs_pkg::REF_ZERO, 0, 0, 8);
        cmd.start <= 1'b0;
        drv(jcs_pkg::REF_ZERO, 0, 0, 4);
        cmd.start <= 1'b1;
        drv(jcs_pkg::REF_NORMAL, 0, 1, 0);
        cmd.start <= 1'b0;
        drv(jcs_pkg::REF_ZERO, 0, 0, 0);
        {cmd.local_sel, cmd.permit, cmd.jog1} <= 3'h7;
        drv(jcs_pkg::REF_ZERO, 0, 0, 10);
        apb(1, jcs_pkg::CTRL_OFFS, 32'h0000_0100, 0, 0);
        drv(jcs_pkg::REF_ZERO, 0, 0, 8);
        cmd <= '0;
        drv(jcs_pkg::REF_JOG1, 1, 1, 0);
        apb(1, jcs_pkg::CTRL_OFFS, 32'h0000_0200, 0, 0);
        drv(jcs_pkg::REF_JOG2, 1, 1, 0);
        apb(0, jcs_pkg::STAT_OFFS, 0, (32'(jcs_pkg::ST_JOG) << jcs_pkg::STAT_STATE_LSB)
            | (32'(jcs_pkg::REF_JOG2) << jcs_pkg::STAT_REF_LSB)
            | (32'h0000_0001 << jcs_pkg::STAT_RAMP_BIT)
            | (32'h0000_0001 << jcs_pkg::STAT_STOK_BIT), 0);
        apb(1, jcs_pkg::CTRL_OFFS, 32'h0000_0000, 0, 0);
        drv(jcs_pkg::REF_ZERO, 1, 1, 0);
        drv(jcs_pkg::REF_ZERO, 0, 0, 0);
        summarize();
    end
endmodule // jcs_sequencer_bench
